// ### common/vic_map.svh
`ifndef VIC_MAP_SVH
`define VIC_MAP_SVH
// ****************************************
// register offsets on the plain port
// ****************************************
`define VIC_REG_REQUEST 8'h00
`define VIC_REG_MASK 8'h01
`define VIC_REG_PRIORITY 8'h02
`define VIC_REG_STATUS 8'h03
// ****************************************
// field positions
// ****************************************
`define VIC_MASK_GLOBAL_BIT 7
`define VIC_STATUS_BUSY_BIT 7
`define VIC_REQ_TX 4
`define VIC_REQ_RX_PIN0 3
`define VIC_REQ_TIMER0 2
`define VIC_REQ_TIMER1 5
`define VIC_REQ_TIMER2 4
// ****************************************
// reset values
// ****************************************
`define VIC_REQUEST_RST 6'h00
`define VIC_MASK_RST 8'h00
`define VIC_PRIORITY_RST 3'h0
`define VIC_PIN_RST 4'hF
// ****************************************
// entry sequence, counted in core_clk cycles
// ****************************************
`define VIC_NUM_REQ 6
`define VIC_SRC_SETUP_CYCLES 5
`define VIC_STACK_CYCLES 6'd48
`define VIC_VECTOR_CYCLES 6'd9
`define VIC_ENTRY_CYCLE (`VIC_STACK_CYCLES + `VIC_VECTOR_CYCLES + 6'd1)
`define VIC_PUSH_PC_LO 6'd16
`define VIC_PUSH_PC_HI 6'd32
`define VIC_PUSH_FLAGS 6'd48
`define VIC_FETCH_HI 6'd50
`define VIC_FETCH_LO 6'd52
`define VIC_VECTOR_BASE 16'h0000
`endif

// ### common/vic_pkg.sv
`default_nettype none
package vic_pkg;
   typedef logic [5:0] vic_req_t;
   typedef enum logic [1:0] {
      VIC_IDLE = 2'b00,
      VIC_STACK = 2'b01,
      VIC_VECTOR = 2'b10
   } vic_state_t;
   typedef enum logic [1:0] {
      VIC_PUSH_LO = 2'b00,
      VIC_PUSH_HI = 2'b01,
      VIC_PUSH_FLG = 2'b10
   } vic_push_t;
endpackage
`default_nettype wire

// ### src/vic_prio.sv
`default_nettype none
module vic_prio (
   input wire vic_pkg::vic_req_t req,
   input wire logic [2:0] start,
   output logic hit,
   output logic [2:0] idx
);
   import vic_pkg::*;
   logic [2:0] first;
   logic [5:0] found;
   logic [2:0] cand [0:5];

   // an out-of-range start code falls back to request 0 first
   assign first = (start > 3'd5) ? 3'd0 : start;

   // ****************************************
   // rotated order: request first, first+1, ...
   // ****************************************
   genvar k;
   generate
      for (k = 0; k < 6; k++) begin : g_rank
         logic [3:0] s;
         assign s = {1'b0, first} + 4'(k);
         assign cand[k] = (s > 4'd5) ? 3'(s - 4'd6) : s[2:0];
         assign found[k] = req[cand[k]];
      end
   endgenerate

   always_comb begin
      hit = |found;
      idx = 3'd0;
      for (int j = 5; j >= 0; j--) begin
         if (found[j]) begin
            idx = cand[j];
         end
      end
   end
endmodule
`default_nettype wire

// ### src/vic_top.sv
// Overview of operation
// - nine sources merge into six maskable requests
// - sources: four pins, serial, three timers
// - pins 0,1,2,3 drive requests 3,2,0,1
// - global and per-request enables gate grants
// - priority register orders simultaneous pending requests
// - per-request vector holds 16-bit routine address
// - grant disables interrupts, saves context, vectors
// - masked requests still latch and read back
// - software setting request bit raises interrupt
// - arbitration only at instruction end sample
// - every transmitted character raises request 4
// - every received character raises request 3
// - 48 stack cycles, nine fetch, entry 58
// - requests stay live and wake halted core
//
// The strobed register port and the register addresses were chosen for this implementation.
`default_nettype none
`include "vic_map.svh"
module vic_top (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [3:0] fixed_input_port_pins,
   input wire logic rx_char_done,
   input wire logic tx_char_done,
   input wire logic timer0_done,
   input wire logic timer1_done,
   input wire logic timer2_done,
   input wire logic instr_end,
   input wire logic core_halted,
   output logic int_grant,
   output logic stack_push,
   output vic_pkg::vic_push_t stack_sel,
   output logic pmem_rd,
   output logic [15:0] pmem_addr,
   input wire logic [7:0] pmem_data,
   output logic pc_load,
   output logic [15:0] isr_addr,
   output logic wake
);
   import vic_pkg::*;

   vic_req_t pend;
   vic_req_t hw_set;
   vic_req_t clr;
   vic_req_t armed;
   logic [3:0] pin_q;
   logic [3:0] pin_fall;
   logic [5:0] mask_en;
   logic glob;
   logic [2:0] prio_start;
   vic_state_t st;
   logic [5:0] cnt;
   logic [2:0] gidx;
   logic hit;
   logic [2:0] win;
   logic busy;
   logic sw_wr_req;

   // ****************************************
   // source merge
   // ****************************************
   // external requests are active-low edges; they keep working while halted
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pin_q <= `VIC_PIN_RST;
      end else begin
         pin_q <= fixed_input_port_pins;
      end
   end
   assign pin_fall = pin_q & ~fixed_input_port_pins;

   always_comb begin
      hw_set = 6'h00;
      hw_set[0] = pin_fall[2];
      hw_set[1] = pin_fall[3];
      hw_set[2] = pin_fall[1] | timer0_done;
      hw_set[3] = pin_fall[0] | rx_char_done;
      hw_set[4] = tx_char_done | timer2_done;
      hw_set[5] = timer1_done;
   end

   // ****************************************
   // pending requests
   // ****************************************
   assign sw_wr_req = reg_wr && (reg_addr == `VIC_REG_REQUEST);
   assign int_grant = instr_end && (st == VIC_IDLE) && glob && hit;

   always_comb begin
      clr = 6'h00;
      if (int_grant) begin
         clr[win] = 1'b1;
      end
   end

   // hardware set wins over both software and grant clears
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pend <= `VIC_REQUEST_RST;
      end else if (sw_wr_req) begin
         pend <= (reg_wdata[5:0] & ~clr) | hw_set;
      end else begin
         pend <= (pend & ~clr) | hw_set;
      end
   end

   // ****************************************
   // mask and priority registers
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         mask_en <= 6'(`VIC_MASK_RST);
         glob <= 1'b0;
      end else begin
         if (reg_wr && (reg_addr == `VIC_REG_MASK)) begin
            mask_en <= reg_wdata[5:0];
            glob <= reg_wdata[`VIC_MASK_GLOBAL_BIT];
         end
         // entry disables nesting even if software writes the mask together
         if (int_grant) begin
            glob <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         prio_start <= `VIC_PRIORITY_RST;
      end else if (reg_wr && (reg_addr == `VIC_REG_PRIORITY)) begin
         prio_start <= reg_wdata[2:0];
      end
   end

   assign armed = pend & mask_en;

   vic_prio u_prio (
      .req(armed),
      .start(prio_start),
      .hit(hit),
      .idx(win)
   );

   // ****************************************
   // entry sequence
   // ****************************************
   assign busy = (st != VIC_IDLE);

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         st <= VIC_IDLE;
         cnt <= 6'd0;
         gidx <= 3'd0;
      end else begin
         unique case (st)
            VIC_IDLE: begin
               if (int_grant) begin
                  st <= VIC_STACK;
                  cnt <= 6'd1;
                  gidx <= win;
               end
            end
            VIC_STACK: begin
               cnt <= cnt + 6'd1;
               if (cnt == `VIC_STACK_CYCLES) begin
                  st <= VIC_VECTOR;
               end
            end
            VIC_VECTOR: begin
               cnt <= cnt + 6'd1;
               if (cnt == `VIC_ENTRY_CYCLE) begin
                  st <= VIC_IDLE;
                  cnt <= 6'd0;
               end
            end
            default: begin
               st <= VIC_IDLE;
               cnt <= 6'd0;
            end
         endcase
      end
   end

   // context save: low pc byte, high pc byte, then flags
   always_comb begin
      stack_push = (st == VIC_STACK) && ((cnt == `VIC_PUSH_PC_LO) || (cnt == `VIC_PUSH_PC_HI) ||
                   (cnt == `VIC_PUSH_FLAGS));
      stack_sel = VIC_PUSH_LO;
      if (cnt == `VIC_PUSH_PC_HI) begin
         stack_sel = VIC_PUSH_HI;
      end else if (cnt == `VIC_PUSH_FLAGS) begin
         stack_sel = VIC_PUSH_FLG;
      end
   end

   assign pmem_rd = (st == VIC_VECTOR) && ((cnt == `VIC_FETCH_HI) || (cnt == `VIC_FETCH_LO));
   assign pc_load = (st == VIC_VECTOR) && (cnt == `VIC_ENTRY_CYCLE);

   // vector pair for request n sits at base + 2n, high byte first
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         pmem_addr <= `VIC_VECTOR_BASE;
      end else if (int_grant) begin
         pmem_addr <= `VIC_VECTOR_BASE + {12'h000, win, 1'b0};
      end else if (pmem_rd && (cnt == `VIC_FETCH_HI)) begin
         pmem_addr <= pmem_addr + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         isr_addr <= 16'h0000;
      end else if (st == VIC_VECTOR && cnt == `VIC_FETCH_HI + 6'd1) begin
         isr_addr[15:8] <= pmem_data;
      end else if (st == VIC_VECTOR && cnt == `VIC_FETCH_LO + 6'd1) begin
         isr_addr[7:0] <= pmem_data;
      end
   end

   // any pending enabled request restarts a halted core while the global enable is set
   assign wake = core_halted && glob && (|armed);

   // ****************************************
   // register read port
   // ****************************************
   always_ff @(posedge core_clk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         unique case (reg_addr)
            `VIC_REG_REQUEST: reg_rdata <= {2'b00, pend};
            `VIC_REG_MASK: reg_rdata <= {glob, 1'b0, mask_en};
            `VIC_REG_PRIORITY: reg_rdata <= {5'h00, prio_start};
            `VIC_REG_STATUS: reg_rdata <= {busy, 4'h0, gidx};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   property p_pin_map;
      @(posedge core_clk) disable iff (!rst_b) $fell(fixed_input_port_pins[0]) && $past(rst_b) |=> pend[3];
   endproperty
   a_pin_map: assert property (p_pin_map) else $error("pin 0 edge did not set request 3");

   property p_tx;
      @(posedge core_clk) disable iff (!rst_b) tx_char_done |=> pend[4];
   endproperty
   a_tx: assert property (p_tx) else $error("transmit done did not set request 4");

   property p_rx;
      @(posedge core_clk) disable iff (!rst_b) rx_char_done |=> pend[3];
   endproperty
   a_rx: assert property (p_rx) else $error("receive done did not set request 3");

   property p_enabled;
      @(posedge core_clk) disable iff (!rst_b) int_grant |-> glob && mask_en[win] && pend[win];
   endproperty
   a_enabled: assert property (p_enabled) else $error("grant of a disabled request");

   property p_sample;
      @(posedge core_clk) disable iff (!rst_b) int_grant |-> instr_end && !busy;
   endproperty
   a_sample: assert property (p_sample) else $error("grant outside instruction end");

   property p_disable;
      @(posedge core_clk) disable iff (!rst_b) int_grant |=> (!glob && !int_grant) [*8];
   endproperty
   a_disable: assert property (p_disable) else $error("interrupts not disabled on grant");

   property p_timing;
      @(posedge core_clk) disable iff (!rst_b) int_grant |-> ##48 stack_push ##10 pc_load;
   endproperty
   a_timing: assert property (p_timing) else $error("entry sequence timing wrong");

   property p_clear;
      @(posedge core_clk) disable iff (!rst_b) int_grant && !hw_set[win] && !sw_wr_req |=> !pend[gidx];
   endproperty
   a_clear: assert property (p_clear) else $error("granted request still pending");

   property p_swset;
      @(posedge core_clk) disable iff (!rst_b) sw_wr_req && !int_grant |=>
         ((pend & $past(reg_wdata[5:0])) == $past(reg_wdata[5:0]));
   endproperty
   a_swset: assert property (p_swset) else $error("software set lost");

   property p_poll;
      @(posedge core_clk) disable iff (!rst_b) reg_rd && reg_addr == `VIC_REG_REQUEST |=>
         reg_rdata[5:0] == $past(pend);
   endproperty
   a_poll: assert property (p_poll) else $error("request read back wrong");

   property p_reset;
      @(posedge core_clk) disable iff (!rst_b) $rose(rst_b) |-> pend == 6'h00 && !glob;
   endproperty
   a_reset: assert property (p_reset) else $error("reset state wrong");

   property p_wake;
      @(posedge core_clk) disable iff (!rst_b) core_halted && glob && (|(hw_set & mask_en)) |=>
         wake || !core_halted || !glob || $changed(mask_en);
   endproperty
   a_wake: assert property (p_wake) else $error("halted core not woken");

   c_grant: cover property (@(posedge core_clk) disable iff (!rst_b) int_grant);
   c_entry: cover property (@(posedge core_clk) disable iff (!rst_b) pc_load);
   c_shared: cover property (@(posedge core_clk) disable iff (!rst_b) rx_char_done && pin_fall[0]);
   c_wake: cover property (@(posedge core_clk) disable iff (!rst_b) wake);
endmodule
`default_nettype wire

// ### dv/vic_pmem_model.sv
`default_nettype none
// ****
// program memory holding the vector table
// ****
module vic_pmem_model (
   input wire logic core_clk,
   input wire logic pmem_rd,
   input wire logic [15:0] pmem_addr,
   output logic [7:0] pmem_data
);
   timeunit 1ns;
   timeprecision 1ps;
   initial pmem_data = 8'h00;
   // byte stands one cycle after the read, then scrambles so a late sample cannot pass
   always @(posedge core_clk) begin
      if (pmem_rd) begin
         pmem_data <= 8'h40 + pmem_addr[7:0];
      end else begin
         pmem_data <= ~pmem_data;
      end
   end
endmodule
`default_nettype wire

// ### dv/testbench.sv
`default_nettype none
`include "vic_map.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_fail++; $display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk, rst_b, reg_wr, reg_rd, instr_end, core_halted;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, pmem_data;
   logic [3:0] pins;
   logic [4:0] src;
   logic int_grant, stack_push, pmem_rd, pc_load, wake;
   logic [15:0] pmem_addr, isr_addr;
   vic_pkg::vic_push_t stack_sel;
   int n_fail = 0;
   int n_checks = 0;

   vic_top DUT (.core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .fixed_input_port_pins(pins),
      .rx_char_done(src[0]), .tx_char_done(src[1]), .timer0_done(src[2]), .timer1_done(src[3]),
      .timer2_done(src[4]),
      .instr_end(instr_end), .core_halted(core_halted), .int_grant(int_grant), .stack_push(stack_push),
      .stack_sel(stack_sel), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_data(pmem_data),
      .pc_load(pc_load), .isr_addr(isr_addr), .wake(wake));

   vic_pmem_model pmem (.core_clk(core_clk), .pmem_rd(pmem_rd), .pmem_addr(pmem_addr), .pmem_data(pmem_data));

   initial begin
      core_clk = 1'b0;
      forever #4 core_clk = ~core_clk;
   end

   // ****
   // register port
   // ****
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] e);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      `CHK(reg_rdata, e)
   endtask

   // ****
   // one instruction boundary that must be taken, walked to routine entry
   // ****
   task automatic entry(input logic [2:0] n);
      logic [3:0] e;
      // let the latched request settle before the boundary is offered
      repeat (`VIC_SRC_SETUP_CYCLES) @(posedge core_clk);
      @(posedge core_clk);
      instr_end <= 1'b1;
      #1;
      `CHK(int_grant, 1'b1)
      for (int k = 1; k < 60; k++) begin
         @(posedge core_clk);
         instr_end <= 1'b0;
         #1;
         e = {1'b0, k == 16 || k == 32 || k == 48, k == 50 || k == 52, k == 58};
         `CHK({int_grant, stack_push, pmem_rd, pc_load}, e)
         if (e[2]) `CHK(stack_sel, 2'(k / 16 - 1))
         if (e[1]) `CHK(pmem_addr, `VIC_VECTOR_BASE + 16'(2 * n + (k == 52)))
      end
      `CHK(isr_addr, {8'h40 + {4'h0, n, 1'b0}, 8'h41 + {4'h0, n, 1'b0}})
   endtask

   // ****
   // scenarios
   // ****
   task automatic check_reset();
      rd(`VIC_REG_REQUEST, 8'h00);
      rd(`VIC_REG_MASK, 8'h00);
      rd(`VIC_REG_PRIORITY, 8'h00);
      rd(`VIC_REG_STATUS, 8'h00);
      rd(8'h04, 8'h00);
   endtask

   task automatic poll_sources();
      logic [7:0] pexp [4] = '{8'h08, 8'h04, 8'h01, 8'h02};
      logic [7:0] sexp [4] = '{8'h08, 8'h10, 8'h04, 8'h20};
      // individual enables on but global off: requests must latch without a grant
      wr(`VIC_REG_MASK, 8'h3F);
      @(posedge core_clk);
      src[4] <= 1'b1;
      @(posedge core_clk);
      src[4] <= 1'b0;
      rd(`VIC_REG_REQUEST, 8'h10);
      for (int i = 0; i < 4; i++) begin
         wr(`VIC_REG_REQUEST, 8'h00);
         @(posedge core_clk);
         pins[i] <= 1'b0;
         @(posedge core_clk);
         pins[i] <= 1'b1;
         rd(`VIC_REG_REQUEST, pexp[i]);
         wr(`VIC_REG_REQUEST, 8'h00);
         @(posedge core_clk);
         src[i] <= 1'b1;
         @(posedge core_clk);
         src[i] <= 1'b0;
         rd(`VIC_REG_REQUEST, sexp[i]);
      end
      @(posedge core_clk);
      instr_end <= 1'b1;
      #1;
      `CHK(int_grant, 1'b0)
      @(posedge core_clk);
      instr_end <= 1'b0;
      rd(`VIC_REG_REQUEST, 8'h20);
   endtask

   task automatic soft_entry();
      wr(`VIC_REG_REQUEST, 8'h20);
      wr(`VIC_REG_MASK, 8'hA0);
      #1;
      `CHK(int_grant, 1'b0)
      entry(3'd5);
      rd(`VIC_REG_MASK, 8'h20);
      rd(`VIC_REG_REQUEST, 8'h00);
      rd(`VIC_REG_STATUS, 8'h05);
   endtask

   task automatic prio_mask();
      wr(`VIC_REG_REQUEST, 8'h09);
      wr(`VIC_REG_PRIORITY, 8'h01);
      rd(`VIC_REG_PRIORITY, 8'h01);
      wr(`VIC_REG_MASK, 8'h89);
      entry(3'd3);
      rd(`VIC_REG_REQUEST, 8'h01);
      wr(`VIC_REG_REQUEST, 8'h09);
      wr(`VIC_REG_MASK, 8'h81);
      entry(3'd0);
      rd(`VIC_REG_REQUEST, 8'h08);
      // start at request 4: the order wraps, so request 0 beats request 3
      wr(`VIC_REG_REQUEST, 8'h09);
      wr(`VIC_REG_PRIORITY, 8'h04);
      wr(`VIC_REG_MASK, 8'h89);
      entry(3'd0);
      rd(`VIC_REG_REQUEST, 8'h08);
      // an out-of-range start serves request 0 first
      wr(`VIC_REG_REQUEST, 8'h0A);
      wr(`VIC_REG_PRIORITY, 8'h07);
      rd(`VIC_REG_PRIORITY, 8'h07);
      wr(`VIC_REG_MASK, 8'h8A);
      entry(3'd1);
      rd(`VIC_REG_REQUEST, 8'h08);
   endtask

   task automatic halted_wake();
      wr(`VIC_REG_REQUEST, 8'h02);
      wr(`VIC_REG_MASK, 8'h82);
      @(posedge core_clk);
      core_halted <= 1'b1;
      #1;
      `CHK(wake, 1'b1)
      wr(`VIC_REG_MASK, 8'h02);
      #1;
      `CHK(wake, 1'b0)
      // a pin edge while halted must still latch and wake the core
      wr(`VIC_REG_REQUEST, 8'h00);
      wr(`VIC_REG_MASK, 8'h82);
      #1;
      `CHK(wake, 1'b0)
      @(posedge core_clk);
      pins[3] <= 1'b0;
      @(posedge core_clk);
      pins[3] <= 1'b1;
      #1;
      `CHK(wake, 1'b1)
      @(posedge core_clk);
      core_halted <= 1'b0;
      #1;
      `CHK(wake, 1'b0)
      rd(`VIC_REG_REQUEST, 8'h02);
   endtask

   task automatic mid_reset();
      @(posedge core_clk);
      rst_b <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      check_reset();
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   initial begin
      rst_b = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      instr_end = 1'b0;
      core_halted = 1'b0;
      pins = 4'hF;
      src = 5'h00;
      repeat (2) @(posedge core_clk);
      rst_b <= 1'b1;
      check_reset();
      poll_sources();
      soft_entry();
      prio_mask();
      halted_wake();
      mid_reset();
      results();
   end

   // the sequence needs under 500 cycles; 12500 cycles, some 25 times that, means a hang
   initial begin
      #100000;
      n_fail++;
      results();
   end
endmodule
`default_nettype wire
